// *** hdl/cfgtr_config_trim.sv ***
// Operation
// - Programmed setup bits read 0, erased bits read 1; programming only clears bits.
// - Program-protect bit 0 blocks external program memory reads and writes.
// - Protected program memory reads over the programming port return zeros.
// - Data-protect bit 0 blocks external data memory reads.
// - Lifting data protection erases the whole data memory.
// - Lifting program protection erases the whole program memory.
// - Reset-pin bit 1 makes pin a reset with pull-up; 0 disables reset.
// - Power-up timer enable is active low.
// - Watchdog bit 1 runs always; 0 leaves it to software enable.
// - Three-bit oscillator field selects one of eight clock sources.
// - Two-bit brown-out field: always, awake only, software, disabled.
// - Fail-safe clock monitor enable follows its bit.
// - Two-speed switchover enable follows its bit.
// - Brown-out enable never turns on the power-up timer by itself.
// - Reset pin asserted in internal or RC clock mode stops internal oscillator.
// - Seven-bit frequency trim is a signed offset around centre.
// - Short trim layout: two-bit power-on threshold, bit 5 reads zero.
// - Short trim layout: brown-out code 000 reserved, 001 lowest, 111 highest.
// - Full trim layout: codes 111..100 and 000..011 step maximum to minimum.
// - Program bulk erase leaves the trim word intact unless it is addressed to the trim word.
module cfgtr_config_trim (
    input  wire logic                     CLK_SYS,
    input  wire logic                     NRST,
    input  wire logic                     TRIM_FULL,
    input  wire logic                     RESET_PIN_N,
    input  wire cfgtr_pkg::cfgtr_req_t    REQ,
    input  wire logic [13:0]              PMEM_RDATA,
    input  wire logic [7:0]               DMEM_RDATA,
    input  wire logic                     SW_WDT_EN,
    input  wire logic                     SW_BOR_EN,
    input  wire logic                     SLEEPING,
    output logic                          READY,
    output logic [13:0]                   RDATA,
    output logic                          RVALID,
    output logic                          PMEM_WR,
    output logic                          PMEM_ERASE,
    output logic                          DMEM_ERASE,
    output cfgtr_pkg::cfgtr_settings_t    SETTINGS,
    output logic                          WDT_RUN,
    output logic                          BOR_ARMED,
    output logic                          EXT_RESET_REQ,
    output logic                          INT_OSC_STOP
);

    typedef enum logic [1:0] {
        ST_SYNC0,
        ST_SYNC1,
        ST_LOAD,
        ST_RUN
    } cfgtr_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rst_pin_s1_ff;
    logic rst_pin_s2_ff;
    logic strap_s1_ff;
    logic strap_s2_ff;
    logic nxt_rst_pin_s1;
    logic nxt_rst_pin_s2;
    logic nxt_strap_s1;
    logic nxt_strap_s2;

    always_comb begin
        nxt_rst_pin_s1 = RESET_PIN_N;
        nxt_rst_pin_s2 = rst_pin_s1_ff;
        nxt_strap_s1   = TRIM_FULL;
        nxt_strap_s2   = strap_s1_ff;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            rst_pin_s1_ff <= 1'b1;
            rst_pin_s2_ff <= 1'b1;
            strap_s1_ff   <= 1'b0;
            strap_s2_ff   <= 1'b0;
        end else begin
            rst_pin_s1_ff <= nxt_rst_pin_s1;
            rst_pin_s2_ff <= nxt_rst_pin_s2;
            strap_s1_ff   <= nxt_strap_s1;
            strap_s2_ff   <= nxt_strap_s2;
        end
    end

    // ------------------------------------------------------------
    // Nonvolatile words, kept across reset
    // ------------------------------------------------------------
    logic [13:0] cfg_nv_ff  = cfgtr_pkg::WORD_ERASED;
    logic [13:0] trim_nv_ff = cfgtr_pkg::WORD_ERASED;
    logic [13:0] nxt_cfg_nv;
    logic [13:0] nxt_trim_nv;

    // ------------------------------------------------------------
    // Start-up sequence and latched words
    // ------------------------------------------------------------
    cfgtr_state_t state_ff;
    cfgtr_state_t nxt_state;
    logic [13:0]  lat_cfg_ff;
    logic [13:0]  lat_trim_ff;
    logic         lat_full_ff;
    logic [13:0]  nxt_lat_cfg;
    logic [13:0]  nxt_lat_trim;
    logic         nxt_lat_full;

    always_comb begin
        nxt_state    = state_ff;
        nxt_lat_cfg  = lat_cfg_ff;
        nxt_lat_trim = lat_trim_ff;
        nxt_lat_full = lat_full_ff;
        unique case (state_ff)
            ST_SYNC0: nxt_state = ST_SYNC1;
            ST_SYNC1: nxt_state = ST_LOAD;
            ST_LOAD: begin
                nxt_lat_cfg  = cfg_nv_ff;
                nxt_lat_trim = trim_nv_ff;
                nxt_lat_full = strap_s2_ff;
                nxt_state    = ST_RUN;
            end
            ST_RUN: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            state_ff    <= ST_SYNC0;
            lat_cfg_ff  <= cfgtr_pkg::WORD_ERASED;
            lat_trim_ff <= cfgtr_pkg::WORD_ERASED;
            lat_full_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            lat_cfg_ff  <= nxt_lat_cfg;
            lat_trim_ff <= nxt_lat_trim;
            lat_full_ff <= nxt_lat_full;
        end
    end

    // ------------------------------------------------------------
    // Field decode of the latched words
    // ------------------------------------------------------------
    cfgtr_pkg::cfgtr_settings_t dec;

    cfgtr_decode u_decode (
        .cfg_word  (lat_cfg_ff[cfgtr_pkg::BIT_CFG_TOP]),
        .trim_word (lat_trim_ff),
        .trim_full (lat_full_ff),
        .cfg_bits  (lat_cfg_ff),
        .settings  (dec)
    );

    // ------------------------------------------------------------
    // Programming port
    // ------------------------------------------------------------
    logic        run;
    logic        live_pprot;
    logic        live_dprot;
    logic        user_addr;
    logic [13:0] trim_view;
    logic [13:0] nxt_rdata;
    logic        nxt_rvalid;
    logic        nxt_pmem_wr;
    logic        nxt_pmem_erase;
    logic        nxt_dmem_erase;

    always_comb begin
        run        = (state_ff == ST_RUN);
        live_pprot = ~cfg_nv_ff[cfgtr_pkg::BIT_PPROT];
        live_dprot = ~cfg_nv_ff[cfgtr_pkg::BIT_DPROT];
        user_addr  = ~REQ.addr[cfgtr_pkg::BIT_CFG_SPC];
        trim_view  = trim_nv_ff;
        trim_view[cfgtr_pkg::BIT_TRIM_TOP] = 1'b0;
        if (!strap_s2_ff) begin
            trim_view[cfgtr_pkg::BIT_TRIM_GAP] = 1'b0;
        end
        nxt_cfg_nv     = cfg_nv_ff;
        nxt_trim_nv    = trim_nv_ff;
        nxt_rdata      = cfgtr_pkg::WORD_ZERO;
        nxt_rvalid     = 1'b0;
        nxt_pmem_wr    = 1'b0;
        nxt_pmem_erase = 1'b0;
        nxt_dmem_erase = 1'b0;
        if (run) begin
            unique case (REQ.cmd)
                cfgtr_pkg::CMD_WRITE: begin
                    if (user_addr) begin
                        nxt_pmem_wr = ~live_pprot;
                    end else if (REQ.addr == cfgtr_pkg::ADDR_CONFIG) begin
                        nxt_cfg_nv = cfg_nv_ff & REQ.data;
                        nxt_cfg_nv[cfgtr_pkg::BIT_CFG_TOP] = 1'b1;
                    end else if (REQ.addr == cfgtr_pkg::ADDR_TRIM) begin
                        nxt_trim_nv = trim_nv_ff & REQ.data;
                    end
                end
                cfgtr_pkg::CMD_READ_PROG: begin
                    nxt_rvalid = 1'b1;
                    if (user_addr) begin
                        nxt_rdata = live_pprot ? cfgtr_pkg::WORD_ZERO : PMEM_RDATA;
                    end else if (REQ.addr == cfgtr_pkg::ADDR_CONFIG) begin
                        nxt_rdata = cfg_nv_ff;
                    end else if (REQ.addr == cfgtr_pkg::ADDR_TRIM) begin
                        nxt_rdata = trim_view;
                    end
                end
                cfgtr_pkg::CMD_READ_DATA: begin
                    nxt_rvalid = 1'b1;
                    if (!live_dprot) begin
                        nxt_rdata = {6'h00, DMEM_RDATA};
                    end
                end
                cfgtr_pkg::CMD_ERASE_PROG: begin
                    nxt_cfg_nv     = cfgtr_pkg::WORD_ERASED;
                    nxt_pmem_erase = 1'b1;
                    nxt_dmem_erase = live_dprot;
                    if (REQ.addr == cfgtr_pkg::ADDR_TRIM) begin
                        nxt_trim_nv = cfgtr_pkg::WORD_ERASED;
                    end
                end
                cfgtr_pkg::CMD_ERASE_DATA: begin
                    nxt_dmem_erase = ~live_dprot;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        cfg_nv_ff  <= nxt_cfg_nv;
        trim_nv_ff <= nxt_trim_nv;
    end

    // ------------------------------------------------------------
    // Device settings and pin-driven outputs
    // ------------------------------------------------------------
    logic nxt_wdt_run;
    logic nxt_bor_armed;
    logic nxt_ext_reset;
    logic nxt_osc_stop;

    always_comb begin
        nxt_wdt_run   = run & (dec.watchdog_enable | SW_WDT_EN);
        nxt_bor_armed = 1'b0;
        if (run) begin
            unique case (dec.brownout_reset_mode)
                cfgtr_pkg::BOR_ON:    nxt_bor_armed = 1'b1;
                cfgtr_pkg::BOR_AWAKE: nxt_bor_armed = ~SLEEPING;
                cfgtr_pkg::BOR_SOFT:  nxt_bor_armed = SW_BOR_EN;
                cfgtr_pkg::BOR_OFF:   nxt_bor_armed = 1'b0;
            endcase
        end
        nxt_ext_reset = run & dec.reset_pin_function & ~rst_pin_s2_ff;
        nxt_osc_stop  = nxt_ext_reset
                      & dec.oscillator_choice[cfgtr_pkg::BIT_OSC_INT];
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            READY         <= 1'b0;
            RDATA         <= cfgtr_pkg::WORD_ZERO;
            RVALID        <= 1'b0;
            PMEM_WR       <= 1'b0;
            PMEM_ERASE    <= 1'b0;
            DMEM_ERASE    <= 1'b0;
            SETTINGS      <= cfgtr_pkg::SETTINGS_RST;
            WDT_RUN       <= 1'b0;
            BOR_ARMED     <= 1'b0;
            EXT_RESET_REQ <= 1'b0;
            INT_OSC_STOP  <= 1'b0;
        end else begin
            READY         <= run;
            RDATA         <= nxt_rdata;
            RVALID        <= nxt_rvalid;
            PMEM_WR       <= nxt_pmem_wr;
            PMEM_ERASE    <= nxt_pmem_erase;
            DMEM_ERASE    <= nxt_dmem_erase;
            SETTINGS      <= run ? dec : cfgtr_pkg::SETTINGS_RST;
            WDT_RUN       <= nxt_wdt_run;
            BOR_ARMED     <= nxt_bor_armed;
            EXT_RESET_REQ <= nxt_ext_reset;
            INT_OSC_STOP  <= nxt_osc_stop;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_load_exit;
        state_ff == ST_LOAD ##1 state_ff == ST_RUN;
    endsequence

    sequence s_erase_prog;
        run && REQ.cmd == cfgtr_pkg::CMD_ERASE_PROG;
    endsequence

    AST_LATCH_AT_EXIT: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        s_load_exit |-> lat_cfg_ff == $past(cfg_nv_ff) && lat_trim_ff == $past(trim_nv_ff))
        else $error("Latched words differ from stored words at reset exit");

    AST_PROGRAM_CLEARS: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        run && REQ.cmd == cfgtr_pkg::CMD_WRITE && REQ.addr == cfgtr_pkg::ADDR_CONFIG
        |=> (cfg_nv_ff & ~$past(cfg_nv_ff)) == cfgtr_pkg::WORD_ZERO)
        else $error("Programming set a setup bit");

    AST_PROG_WRITE_BLOCK: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PMEM_WR |-> $past(run && !live_pprot && REQ.cmd == cfgtr_pkg::CMD_WRITE))
        else $error("Program write passed while protected");

    AST_PROG_READ_ZERO: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        run && REQ.cmd == cfgtr_pkg::CMD_READ_PROG && user_addr && live_pprot
        |=> RVALID && RDATA == cfgtr_pkg::WORD_ZERO)
        else $error("Protected program read returned data");

    AST_DATA_READ_ZERO: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        run && REQ.cmd == cfgtr_pkg::CMD_READ_DATA && live_dprot
        |=> RVALID && RDATA == cfgtr_pkg::WORD_ZERO)
        else $error("Protected data read returned data");

    AST_DATA_ERASE_ON_UNLOCK: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        s_erase_prog ##0 live_dprot |=> DMEM_ERASE && PMEM_ERASE)
        else $error("Data memory not erased when protection lifted");

    AST_PROG_ERASE: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        s_erase_prog |=> PMEM_ERASE && cfg_nv_ff == cfgtr_pkg::WORD_ERASED
            ##1 PMEM_ERASE == $past(run && REQ.cmd == cfgtr_pkg::CMD_ERASE_PROG))
        else $error("Program erase did not clear setup word");

    AST_TRIM_KEPT: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        s_erase_prog ##0 REQ.addr != cfgtr_pkg::ADDR_TRIM |=> $stable(trim_nv_ff))
        else $error("Trim word lost in bulk erase");

    AST_RESET_PIN: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        EXT_RESET_REQ |-> $past(dec.reset_pin_function && !rst_pin_s2_ff))
        else $error("Reset request without enabled reset pin");

    AST_OSC_STOP: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        INT_OSC_STOP |-> EXT_RESET_REQ
            && $past(dec.oscillator_choice[cfgtr_pkg::BIT_OSC_INT]))
        else $error("Oscillator stopped outside internal or RC mode");

    AST_WATCHDOG: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        run && dec.watchdog_enable |=> WDT_RUN)
        else $error("Watchdog not running while enabled by setup");

    AST_POWERUP_TIMER_OWN_BIT: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        $past(run) && run
        |-> SETTINGS.powerup_timer_enable == ~lat_cfg_ff[cfgtr_pkg::BIT_POWERUP_TIMER])
        else $error("Power-up timer does not follow its own bit");

endmodule : cfgtr_config_trim

// *** hdl/cfgtr_decode.sv ***
module cfgtr_decode (
    input  wire logic                     cfg_word,
    input  wire logic [13:0]              trim_word,
    input  wire logic                     trim_full,
    input  wire logic [13:0]              cfg_bits,
    output cfgtr_pkg::cfgtr_settings_t    settings
);

    // ------------------------------------------------------------
    // Threshold code to rank, centre codes share one rank
    // ------------------------------------------------------------
    function automatic logic [2:0] thr_rank(input logic [2:0] code);
        logic [2:0] r;
        r = 3'h0;
        unique case (code)
            3'h3: r = 3'h0;
            3'h2: r = 3'h1;
            3'h1: r = 3'h2;
            3'h0: r = 3'h3;
            3'h4: r = 3'h3;
            3'h5: r = 3'h4;
            3'h6: r = 3'h5;
            3'h7: r = 3'h6;
        endcase
        return r;
    endfunction : thr_rank

    logic [2:0] por_code;
    logic [2:0] bor_code;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    always_comb begin
        por_code = trim_word[cfgtr_pkg::POR_LSB +: cfgtr_pkg::THR_W];
        bor_code = trim_word[cfgtr_pkg::BOR_THR_LSB +: cfgtr_pkg::THR_W];
        settings = cfgtr_pkg::SETTINGS_RST;
        settings.prog_protect         = ~cfg_bits[cfgtr_pkg::BIT_PPROT];
        settings.data_protect         = ~cfg_bits[cfgtr_pkg::BIT_DPROT];
        settings.reset_pin_function   = cfg_bits[cfgtr_pkg::BIT_RSTPIN];
        settings.reset_pin_pullup     = cfg_bits[cfgtr_pkg::BIT_RSTPIN];
        settings.powerup_timer_enable = ~cfg_bits[cfgtr_pkg::BIT_POWERUP_TIMER];
        settings.watchdog_enable      = cfg_bits[cfgtr_pkg::BIT_WDT];
        settings.brownout_reset_mode  =
            cfgtr_pkg::cfgtr_bor_t'(cfg_bits[cfgtr_pkg::BOR_MODE_LSB +: 2]);
        settings.failsafe_clock_monitor_enable = cfg_bits[cfgtr_pkg::BIT_FSCM];
        settings.two_speed_switchover_enable   = cfg_bits[cfgtr_pkg::BIT_SWO];
        settings.oscillator_choice =
            cfgtr_pkg::cfgtr_osc_t'(cfg_bits[cfgtr_pkg::OSC_LSB +: 3]);
        settings.oscillator_frequency_trim =
            $signed(trim_word[cfgtr_pkg::FREQ_LSB +: cfgtr_pkg::FREQ_W]);
        if (trim_full) begin
            settings.por_threshold_rank      = thr_rank(por_code);
            settings.brownout_threshold_rank = thr_rank(bor_code);
        end else begin
            settings.por_threshold_rank =
                {1'b0, trim_word[cfgtr_pkg::POR_LSB +: cfgtr_pkg::POR_SHORT_W]};
            settings.brownout_threshold_rank = bor_code - cfgtr_pkg::BOR_THR_STEP;
            settings.brownout_threshold_reserved =
                (bor_code == cfgtr_pkg::BOR_THR_RSVD);
        end
    end

    logic unused_cfg_word;
    assign unused_cfg_word = cfg_word;

endmodule : cfgtr_decode

// *** hdl/cfgtr_pkg.sv ***
package cfgtr_pkg;

    // ------------------------------------------------------------
    // Word geometry and addresses
    // ------------------------------------------------------------
    localparam int          WORD_W      = 14;
    localparam int          DATA_W      = 8;
    localparam logic [13:0] ADDR_CONFIG = 14'h2007;
    localparam logic [13:0] ADDR_TRIM   = 14'h2008;
    localparam int          BIT_CFG_SPC = 13;
    localparam logic [13:0] WORD_ERASED = 14'h3FFF;
    localparam logic [13:0] WORD_ZERO   = 14'h0000;

    // ------------------------------------------------------------
    // Setup word fields
    // ------------------------------------------------------------
    localparam int BIT_CFG_TOP = 13;
    localparam int BIT_FSCM    = 11;
    localparam int BIT_SWO     = 10;
    localparam int BOR_MODE_LSB = 8;
    localparam int BIT_DPROT   = 7;
    localparam int BIT_PPROT   = 6;
    localparam int BIT_RSTPIN  = 5;
    localparam int BIT_POWERUP_TIMER    = 4;
    localparam int BIT_WDT     = 3;
    localparam int OSC_LSB     = 0;
    localparam int BIT_OSC_INT = 2;

    // ------------------------------------------------------------
    // Trim word fields
    // ------------------------------------------------------------
    localparam int BIT_TRIM_TOP = 13;
    localparam int FREQ_LSB     = 6;
    localparam int FREQ_W       = 7;
    localparam int POR_LSB      = 3;
    localparam int POR_SHORT_W  = 2;
    localparam int BIT_TRIM_GAP = 5;
    localparam int THR_W        = 3;
    localparam int BOR_THR_LSB  = 0;
    localparam logic [2:0] BOR_THR_RSVD = 3'h0;
    localparam logic [2:0] BOR_THR_STEP = 3'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OSC_CRYSTAL_LOW_POWER  = 3'h0,
        OSC_CRYSTAL_STANDARD   = 3'h1,
        OSC_CRYSTAL_HIGH_SPEED = 3'h2,
        OSC_EXTERNAL_CLOCK     = 3'h3,
        OSC_INTERNAL_PINS_IO   = 3'h4,
        OSC_INTERNAL_CLK_OUT   = 3'h5,
        OSC_EXT_RC_PINS_IO     = 3'h6,
        OSC_EXT_RC_CLK_OUT     = 3'h7
    } cfgtr_osc_t;

    typedef enum logic [1:0] {
        BOR_OFF   = 2'h0,
        BOR_SOFT  = 2'h1,
        BOR_AWAKE = 2'h2,
        BOR_ON    = 2'h3
    } cfgtr_bor_t;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_WRITE,
        CMD_READ_PROG,
        CMD_READ_DATA,
        CMD_ERASE_PROG,
        CMD_ERASE_DATA
    } cfgtr_cmd_t;

    typedef struct packed {
        cfgtr_cmd_t  cmd;
        logic [13:0] addr;
        logic [13:0] data;
    } cfgtr_req_t;

    typedef struct packed {
        logic              prog_protect;
        logic              data_protect;
        logic              reset_pin_function;
        logic              reset_pin_pullup;
        logic              powerup_timer_enable;
        logic              watchdog_enable;
        cfgtr_bor_t        brownout_reset_mode;
        logic              failsafe_clock_monitor_enable;
        logic              two_speed_switchover_enable;
        cfgtr_osc_t        oscillator_choice;
        logic signed [6:0] oscillator_frequency_trim;
        logic [2:0]        por_threshold_rank;
        logic [2:0]        brownout_threshold_rank;
        logic              brownout_threshold_reserved;
    } cfgtr_settings_t;

    localparam cfgtr_settings_t SETTINGS_RST = '0;

endpackage : cfgtr_pkg

// *** sim/cfgtr_prog_model.sv ***
module cfgtr_prog_model (
    input  wire logic             clk,
    input  wire logic [13:0]      rdata,
    output cfgtr_pkg::cfgtr_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Programmer requests
    // ------------------------------------------------------------
    initial begin
        req = '0;
    end

    task automatic xfer(input cfgtr_pkg::cfgtr_cmd_t c, input logic [13:0] a,
                        input logic [13:0] d);
        @(posedge clk);
        req <= '{c, a, d};
        @(posedge clk);
        req <= '{cfgtr_pkg::CMD_NONE, ~a, ~d};
        #1;
    endtask : xfer

    // Trim saved as read back, whatever its value
    task automatic erase_keep_trim();
        logic [13:0] kept;
        xfer(cfgtr_pkg::CMD_READ_PROG, cfgtr_pkg::ADDR_TRIM, 14'h0000);
        kept = rdata;
        xfer(cfgtr_pkg::CMD_ERASE_PROG, cfgtr_pkg::ADDR_TRIM, 14'h0000);
        xfer(cfgtr_pkg::CMD_WRITE, cfgtr_pkg::ADDR_TRIM, kept);
    endtask : erase_keep_trim
endmodule : cfgtr_prog_model

// *** sim/tb_cfgtr_config_trim.sv ***
module tb_cfgtr_config_trim;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS, NRST, TRIM_FULL, RESET_PIN_N, SW_WDT_EN, SW_BOR_EN, SLEEPING;
    logic READY, RVALID, PMEM_WR, PMEM_ERASE, DMEM_ERASE;
    logic WDT_RUN, BOR_ARMED, EXT_RESET_REQ, INT_OSC_STOP;
    logic [13:0] RDATA;
    cfgtr_pkg::cfgtr_req_t REQ;
    cfgtr_pkg::cfgtr_settings_t S;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;

    cfgtr_config_trim uut (.CLK_SYS(CLK_SYS), .NRST(NRST), .TRIM_FULL(TRIM_FULL),
        .RESET_PIN_N(RESET_PIN_N), .REQ(REQ), .PMEM_RDATA(14'h1234), .DMEM_RDATA(8'hA5),
        .SW_WDT_EN(SW_WDT_EN), .SW_BOR_EN(SW_BOR_EN), .SLEEPING(SLEEPING), .READY(READY),
        .RDATA(RDATA), .RVALID(RVALID), .PMEM_WR(PMEM_WR), .PMEM_ERASE(PMEM_ERASE),
        .DMEM_ERASE(DMEM_ERASE), .SETTINGS(S), .WDT_RUN(WDT_RUN), .BOR_ARMED(BOR_ARMED),
        .EXT_RESET_REQ(EXT_RESET_REQ), .INT_OSC_STOP(INT_OSC_STOP));
    cfgtr_prog_model prog (.clk(CLK_SYS), .rdata(RDATA), .req(REQ));

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end

    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [13:0] g, input logic [13:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("FAIL %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic rst();
        @(posedge CLK_SYS);
        NRST <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
        #1;
        chk(READY, 1'b1);
    endtask : rst

    task automatic rd(input logic [13:0] a, input logic [13:0] e);
        prog.xfer(cfgtr_pkg::CMD_READ_PROG, a, 14'h0000);
        chk(RDATA, e);
    endtask : rd

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        NRST = 1'b0;
        TRIM_FULL = 1'b1;
        RESET_PIN_N = 1'b1;
        SW_WDT_EN = 1'b0;
        SW_BOR_EN = 1'b0;
        SLEEPING = 1'b0;
        rst();
        rd(cfgtr_pkg::ADDR_CONFIG, 14'h3FFF);
        rd(14'h0010, 14'h1234);
        prog.xfer(cfgtr_pkg::CMD_WRITE, cfgtr_pkg::ADDR_CONFIG, 14'h3A25);
        prog.xfer(cfgtr_pkg::CMD_WRITE, cfgtr_pkg::ADDR_CONFIG, 14'h3FFF);
        rd(cfgtr_pkg::ADDR_CONFIG, 14'h3A25);
        prog.xfer(cfgtr_pkg::CMD_WRITE, cfgtr_pkg::ADDR_TRIM, 14'h1FC9);
        rd(14'h0010, 14'h0000);
        chk(RVALID, 1'b1);
        prog.xfer(cfgtr_pkg::CMD_WRITE, 14'h0010, 14'h0000);
        chk(PMEM_WR, 1'b0);
        prog.xfer(cfgtr_pkg::CMD_READ_DATA, 14'h0010, 14'h0000);
        chk(RDATA, 14'h0000);
        prog.xfer(cfgtr_pkg::CMD_ERASE_DATA, 14'h0010, 14'h0000);
        chk(DMEM_ERASE, 1'b0);
        rst();
        chk(S.oscillator_choice, cfgtr_pkg::OSC_INTERNAL_CLK_OUT);
        chk(S.brownout_reset_mode, cfgtr_pkg::BOR_AWAKE);
        chk({S.failsafe_clock_monitor_enable, S.two_speed_switchover_enable}, 2'h2);
        chk({S.powerup_timer_enable, S.watchdog_enable}, 2'h2);
        chk(S.reset_pin_function, 1'b1);
        chk({7'h00, S.oscillator_frequency_trim}, 14'h007F);
        chk({S.por_threshold_rank, S.brownout_threshold_rank}, 6'h12);
        chk({S.prog_protect, S.data_protect, S.reset_pin_pullup}, 3'h7);
        chk({BOR_ARMED, WDT_RUN}, 2'h2);
        @(posedge CLK_SYS);
        SLEEPING <= 1'b1;
        SW_WDT_EN <= 1'b1;
        RESET_PIN_N <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        #1;
        chk({BOR_ARMED, WDT_RUN}, 2'h1);
        chk({EXT_RESET_REQ, INT_OSC_STOP}, 2'h3);
        @(posedge CLK_SYS);
        RESET_PIN_N <= 1'b1;
        prog.xfer(cfgtr_pkg::CMD_ERASE_PROG, cfgtr_pkg::ADDR_CONFIG, 14'h0000);
        chk({PMEM_ERASE, DMEM_ERASE}, 2'h3);
        rd(cfgtr_pkg::ADDR_CONFIG, 14'h3FFF);
        chk({EXT_RESET_REQ, INT_OSC_STOP}, 2'h0);
        prog.xfer(cfgtr_pkg::CMD_ERASE_DATA, 14'h0010, 14'h0000);
        chk(DMEM_ERASE, 1'b1);
        prog.xfer(cfgtr_pkg::CMD_READ_DATA, 14'h0010, 14'h0000);
        chk(RDATA, 14'h00A5);
        prog.xfer(cfgtr_pkg::CMD_WRITE, 14'h0010, 14'h0000);
        chk(PMEM_WR, 1'b1);
        rd(cfgtr_pkg::ADDR_TRIM, 14'h1FC9);
        prog.erase_keep_trim();
        rd(cfgtr_pkg::ADDR_TRIM, 14'h1FC9);
        @(posedge CLK_SYS);
        TRIM_FULL <= 1'b0;
        rst();
        chk({S.por_threshold_rank, S.brownout_threshold_rank}, 6'h08);
        chk(S.brownout_threshold_reserved, 1'b0);
        chk({BOR_ARMED, WDT_RUN}, 2'h3);
        prog.xfer(cfgtr_pkg::CMD_ERASE_PROG, cfgtr_pkg::ADDR_TRIM, 14'h0000);
        rd(cfgtr_pkg::ADDR_TRIM, 14'h1FDF);
        report_and_stop();
    end
endmodule : tb_cfgtr_config_trim
